// File: verilog/t2c_params.svh
`ifndef T2C_PARAMS_SVH
`define T2C_PARAMS_SVH

// ==========================================
// register byte offsets
`define T2C_OFF_CTRL 8'hC8
`define T2C_OFF_CFG 8'hCC
`define T2C_OFF_STAT 8'hD0
`define T2C_OFF_MASK 8'hD4
`define T2C_OFF_COUNT 8'hD8
`define T2C_OFF_RELOAD 8'hDC

// ==========================================
// reset values and field positions
`define T2C_RST_CTRL 8'h00
`define T2C_RST_CFG 2'h0
`define T2C_RST_EVT 2'h0
`define T2C_RST_COUNT 16'h0000
`define T2C_CNT_MAX 16'hFFFF
`define T2C_CFG_UPDOWN 0
`define T2C_CFG_IRQEN 1
`define T2C_EVT_OVF 0
`define T2C_EVT_EXT 1

// ==========================================
// bus answers
`define T2C_RESP_OKAY 2'h0
`define T2C_RESP_SLVERR 2'h2
`endif

// File: verilog/t2c_pkg.sv
package t2c_pkg;

  typedef struct packed {
    logic overflowFlag;
    logic externalEventFlag;
    logic serialRxClockSelect;
    logic serialTxClockSelect;
    logic externalTriggerEnable;
    logic runControl;
    logic timerCounterSelect;
    logic captureReloadSelect;
  } t2c_ctrl_t;

  typedef enum logic [2:0] {
    SEL_CTRL = 3'b000,
    SEL_CFG = 3'b001,
    SEL_STAT = 3'b010,
    SEL_MASK = 3'b011,
    SEL_COUNT = 3'b100,
    SEL_RELOAD = 3'b101,
    SEL_NONE = 3'b110
  } t2c_sel_t;

endpackage

// File: verilog/t2c_timer2_control.sv
`timescale 1ns/100ps
`include "t2c_params.svh"

module t2c_timer2_control #(
  parameter int ADDR_W = 8
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic ce, // clock enable, low freezes all state
  input wire logic countInputPin, // external count pin, asynchronous
  input wire logic triggerPin, // capture/reload trigger pin, asynchronous
  input wire logic timer1Overflow, // timer 1 overflow pulse
  input wire logic serialMode13, // serial port is in mode 1 or 3
  output logic timerIrq, // timer interrupt request to the cpu
  output logic irq, // masked sticky event interrupt
  output logic rxBaudTick, // receive baud clock pulse
  output logic txBaudTick, // transmit baud clock pulse
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  function automatic t2c_pkg::t2c_sel_t decodeAddr(input logic [ADDR_W-1:0] addr);
    logic [7:0] low;
    low = 8'(addr);
    if ((ADDR_W > 8) && ((addr >> 8) != '0)) begin
      return t2c_pkg::SEL_NONE;
    end
    case (low)
      `T2C_OFF_CTRL: return t2c_pkg::SEL_CTRL;
      `T2C_OFF_CFG: return t2c_pkg::SEL_CFG;
      `T2C_OFF_STAT: return t2c_pkg::SEL_STAT;
      `T2C_OFF_MASK: return t2c_pkg::SEL_MASK;
      `T2C_OFF_COUNT: return t2c_pkg::SEL_COUNT;
      `T2C_OFF_RELOAD: return t2c_pkg::SEL_RELOAD;
      default: return t2c_pkg::SEL_NONE;
    endcase
  endfunction

  t2c_pkg::t2c_ctrl_t ctrl;
  logic [1:0] cfg;
  logic [1:0] evtStatus;
  logic [1:0] evtMask;
  logic [15:0] count;
  logic [15:0] capReload;

  // ==========================================
  // pin synchronisers and edge detect
  logic [1:0] pinRaw;
  logic [1:0] pinMeta;
  logic [1:0] pinSync;
  logic [1:0] pinLast;
  assign pinRaw = {triggerPin, countInputPin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          pinMeta[gi] <= 1'b1;
          pinSync[gi] <= 1'b1;
          pinLast[gi] <= 1'b1;
        end else if (ce) begin
          pinMeta[gi] <= pinRaw[gi];
          pinSync[gi] <= pinMeta[gi];
          pinLast[gi] <= pinSync[gi];
        end
      end
    end
  endgenerate

  logic countFall;
  logic trigFall;
  assign countFall = pinLast[0] & ~pinSync[0];
  assign trigFall = pinLast[1] & ~pinSync[1];

  // ==========================================
  // register bus, write side
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  t2c_pkg::t2c_sel_t wrSel;
  assign doWrite = ce & awHeld & wHeld & ~s_axi_bvalid;
  assign wrSel = decodeAddr(awAddr);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `T2C_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end else if (!awHeld) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end else if (!wHeld) begin
        s_axi_wready <= 1'b1;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrSel == t2c_pkg::SEL_NONE) ? `T2C_RESP_SLVERR : `T2C_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic ctrlWr;
  logic cfgWr;
  logic statWr;
  logic maskWr;
  logic [1:0] countWr;
  logic [1:0] reloadWr;
  assign ctrlWr = doWrite & (wrSel == t2c_pkg::SEL_CTRL) & wStrb[0];
  assign cfgWr = doWrite & (wrSel == t2c_pkg::SEL_CFG) & wStrb[0];
  assign statWr = doWrite & (wrSel == t2c_pkg::SEL_STAT) & wStrb[0];
  assign maskWr = doWrite & (wrSel == t2c_pkg::SEL_MASK) & wStrb[0];
  assign countWr = {2{doWrite & (wrSel == t2c_pkg::SEL_COUNT)}} & wStrb[1:0];
  assign reloadWr = {2{doWrite & (wrSel == t2c_pkg::SEL_RELOAD)}} & wStrb[1:0];

  // ==========================================
  // counting engine
  logic baudMode;
  logic countUp;
  logic incTick;
  logic ovfUp;
  logic ovfDown;
  logic ovfEvt;
  logic trigEvt;
  logic captureEvt;
  logic reloadOnTrig;
  logic reloadOnOvf;

  assign baudMode = ctrl.serialRxClockSelect | ctrl.serialTxClockSelect;
  // direction comes from the trigger level only in up/down mode
  assign countUp = ~cfg[`T2C_CFG_UPDOWN] | pinSync[1];
  assign incTick = ctrl.runControl & (ctrl.timerCounterSelect ? countFall : 1'b1);
  assign ovfUp = incTick & countUp & (count == `T2C_CNT_MAX);
  assign ovfDown = incTick & ~countUp & (count == capReload);
  assign ovfEvt = ovfUp | ovfDown;
  // trigger is dead for timer use while disabled or clocking the serial port
  assign trigEvt = trigFall & ctrl.externalTriggerEnable & ~baudMode;
  assign captureEvt = trigEvt & ctrl.captureReloadSelect;
  assign reloadOnTrig = trigEvt & ~ctrl.captureReloadSelect;
  assign reloadOnOvf = baudMode | ~ctrl.captureReloadSelect;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= `T2C_RST_COUNT;
    end else if (ce) begin
      if (countWr != 2'b00) begin
        if (countWr[0]) begin
          count[7:0] <= wData[7:0];
        end
        if (countWr[1]) begin
          count[15:8] <= wData[15:8];
        end
      end else if (reloadOnTrig) begin
        count <= capReload;
      end else if (ovfUp) begin
        count <= reloadOnOvf ? capReload : `T2C_RST_COUNT;
      end else if (ovfDown) begin
        count <= `T2C_CNT_MAX;
      end else if (incTick) begin
        count <= countUp ? 16'(count + 16'h0001) : 16'(count - 16'h0001);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      capReload <= `T2C_RST_COUNT;
    end else if (ce) begin
      if (captureEvt) begin
        capReload <= count;
      end else begin
        if (reloadWr[0]) begin
          capReload[7:0] <= wData[7:0];
        end
        if (reloadWr[1]) begin
          capReload[15:8] <= wData[15:8];
        end
      end
    end
  end

  // ==========================================
  // control register and flags
  logic ovfFlagSet;
  assign ovfFlagSet = ovfEvt & ~baudMode;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= t2c_pkg::t2c_ctrl_t'(`T2C_RST_CTRL);
    end else if (ce) begin
      if (ctrlWr) begin
        ctrl <= t2c_pkg::t2c_ctrl_t'(wData[7:0]);
      end
      // a set in the cycle of a software clear wins
      if (ovfFlagSet) begin
        ctrl.overflowFlag <= 1'b1;
      end
      if (trigEvt) begin
        ctrl.externalEventFlag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg <= `T2C_RST_CFG;
    end else if (ce && cfgWr) begin
      cfg <= wData[1:0];
    end
  end

  // ==========================================
  // sticky events, mask and interrupt lines
  logic [1:0] evtSet;
  assign evtSet = {trigEvt, ovfFlagSet};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evtStatus <= `T2C_RST_EVT;
      evtMask <= `T2C_RST_EVT;
    end else if (ce) begin
      evtStatus <= (evtStatus & ~({2{statWr}} & wData[1:0])) | evtSet;
      if (maskWr) begin
        evtMask <= wData[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq <= 1'b0;
      timerIrq <= 1'b0;
    end else if (ce) begin
      irq <= |(evtStatus & evtMask);
      timerIrq <= cfg[`T2C_CFG_IRQEN] &
        (ctrl.overflowFlag | (ctrl.externalEventFlag & ~cfg[`T2C_CFG_UPDOWN]));
    end
  end

  // ==========================================
  // serial baud source selection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxBaudTick <= 1'b0;
      txBaudTick <= 1'b0;
    end else if (ce) begin
      rxBaudTick <= serialMode13 & (ctrl.serialRxClockSelect ? ovfEvt : timer1Overflow);
      txBaudTick <= serialMode13 & (ctrl.serialTxClockSelect ? ovfEvt : timer1Overflow);
    end
  end

  // ==========================================
  // register bus, read side; one cycle from address to data
  t2c_pkg::t2c_sel_t rdSel;
  logic [31:0] rdWord;
  assign rdSel = decodeAddr(s_axi_araddr);

  always_comb begin
    rdWord = 32'h00000000;
    case (rdSel)
      t2c_pkg::SEL_CTRL: rdWord[7:0] = ctrl;
      t2c_pkg::SEL_CFG: rdWord[1:0] = cfg;
      t2c_pkg::SEL_STAT: rdWord[1:0] = evtStatus;
      t2c_pkg::SEL_MASK: rdWord[1:0] = evtMask;
      t2c_pkg::SEL_COUNT: rdWord[15:0] = count;
      t2c_pkg::SEL_RELOAD: rdWord[15:0] = capReload;
      default: rdWord = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `T2C_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= (rdSel == t2c_pkg::SEL_NONE) ? `T2C_RESP_SLVERR : `T2C_RESP_OKAY;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_OVF_SET: assert property (ce && ovfEvt && !baudMode |=> ctrl.overflowFlag)
    else $error("overflow did not set the overflow flag");
  AST_OVF_BAUD: assert property (ce && ovfEvt && baudMode && !ctrl.overflowFlag && !ctrlWr
    |=> !ctrl.overflowFlag)
    else $error("overflow flag set while clocking the serial port");
  AST_EXT_SET: assert property (ce && trigFall && ctrl.externalTriggerEnable && !baudMode
    |=> ctrl.externalEventFlag)
    else $error("trigger edge did not set the external event flag");
  AST_TIRQ: assert property (ce && ctrl.externalEventFlag && cfg[`T2C_CFG_IRQEN] && !cfg[`T2C_CFG_UPDOWN]
    |=> timerIrq)
    else $error("external event flag did not request the timer interrupt");
  AST_NO_UPDOWN_IRQ: assert property (ce && cfg[`T2C_CFG_UPDOWN] && !ctrl.overflowFlag |=> !timerIrq)
    else $error("external event flag interrupted in up/down mode");
  AST_FLAG_HOLD: assert property (ce && ctrl.externalEventFlag && !ctrlWr |=> ctrl.externalEventFlag)
    else $error("external event flag cleared without a write");
  AST_TRIG_IGNORED: assert property (ce && trigFall && !ctrl.externalTriggerEnable && !ctrl.externalEventFlag
    && !ctrlWr |=> !ctrl.externalEventFlag)
    else $error("trigger edge acted while disabled");
  AST_STOPPED: assert property (ce && !ctrl.runControl && countWr == 2'b00 && !reloadOnTrig
    |=> count == $past(count))
    else $error("count moved while stopped");
  AST_TIMER_INC: assert property (ce && ctrl.runControl && !ctrl.timerCounterSelect && !cfg[`T2C_CFG_UPDOWN]
    && count != `T2C_CNT_MAX && countWr == 2'b00 && !reloadOnTrig
    |=> count == 16'($past(count) + 16'h0001))
    else $error("timer mode did not advance every clock");
  AST_RX_BAUD: assert property (ce && serialMode13 && ctrl.serialRxClockSelect && ovfEvt |=> rxBaudTick)
    else $error("receive baud tick missing on own overflow");
  AST_FORCED_RELOAD: assert property (ce && baudMode && ovfUp && countWr == 2'b00
    |=> count == $past(capReload))
    else $error("overflow did not reload in baud mode");
  AST_CAPTURE: assert property (ce && trigEvt && ctrl.captureReloadSelect |=> capReload == $past(count))
    else $error("trigger edge did not capture the count");

endmodule

// File: bench/t2c_pin_model.sv
`timescale 1ns/100ps

// ==========================================
// far-side pins: count and trigger, both idle high
module t2c_pin_model (
  input wire logic clock, // system clock
  output logic countInputPin, // external count pin
  output logic triggerPin // capture/reload trigger pin
);
  initial begin
    countInputPin = 1'b1;
    triggerPin = 1'b1;
  end

  // wide phases so the two-flop synchroniser and edge flop see every edge
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      @(posedge clock);
      if (trig) triggerPin <= 1'b0;
      else countInputPin <= 1'b0;
      repeat (4) @(posedge clock);
      if (trig) triggerPin <= 1'b1;
      else countInputPin <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
endmodule

// File: bench/tb_timer2_control.sv
`timescale 1ns/100ps
`include "t2c_params.svh"

module tb_timer2_control;
  localparam logic [7:0] OCTRL = `T2C_OFF_CTRL;
  localparam logic [7:0] OCFG = `T2C_OFF_CFG;
  localparam logic [7:0] OSTAT = `T2C_OFF_STAT;
  localparam logic [7:0] OMASK = `T2C_OFF_MASK;
  localparam logic [7:0] OCNT = `T2C_OFF_COUNT;
  localparam logic [7:0] ORLD = `T2C_OFF_RELOAD;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic timer1Overflow = 1'b0;
  logic serialMode13 = 1'b0;
  logic countInputPin, triggerPin, timerIrq, irq, rxBaudTick, txBaudTick;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp, wrResp;
  int mismatches = 0, check_count = 0, rxTicks = 0, txTicks = 0, rx0, tx0;

  always #20 clock = ~clock;

  always @(posedge clock) begin
    if (rxBaudTick === 1'b1) rxTicks++;
    if (txBaudTick === 1'b1) txTicks++;
  end

  t2c_pin_model pins (.clock(clock), .countInputPin(countInputPin), .triggerPin(triggerPin));

  t2c_timer2_control dut (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .countInputPin(countInputPin),
    .triggerPin(triggerPin), .timer1Overflow(timer1Overflow), .serialMode13(serialMode13),
    .timerIrq(timerIrq), .irq(irq), .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ==========================================
  // bus tasks and checking
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aDone = 1'b0;
    bit wDone = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(posedge clock);
      aDone |= s_axi_awready;
      wDone |= s_axi_wready;
      s_axi_awvalid <= !aDone;
      s_axi_wvalid <= !wDone;
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    wrResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, rdVal, e);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    mismatches++;
    wrap_up();
  end

  // ==========================================
  // tests
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rc(OCTRL + 8'(4 * i), 32'h0, "reset value");
    rd(8'hE0);
    chk("unmapped data", rdVal, 32'h0);
    chk("unmapped resp", {30'h0, rdResp}, {30'h0, `T2C_RESP_SLVERR});
    wr(8'hE0, 32'hFF);
    chk("unmapped write resp", {30'h0, wrResp}, {30'h0, `T2C_RESP_SLVERR});
    // timer mode from 0xFFF0 overflows within the wait, then reloads
    wr(ORLD, 32'h1000);
    wr(OCNT, 32'hFFF0);
    chk("write resp", {30'h0, wrResp}, {30'h0, `T2C_RESP_OKAY});
    wr(OCTRL, 32'h04);
    repeat (30) @(posedge clock);
    rc(OCTRL, 32'h84, "overflow flag set");
    wr(OCTRL, 32'h80);
    rd(OCNT);
    chk("reload on overflow", {24'h0, rdVal[15:8]}, 32'h10);
    repeat (20) @(posedge clock);
    rc(OCTRL, 32'h80, "overflow flag held");
    rc(OSTAT, 32'h1, "overflow status");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(OMASK, 32'h3);
    repeat (2) @(posedge clock);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(OSTAT, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(OCTRL, 32'h00);
    rc(OCTRL, 32'h00, "flag cleared by software");
    // counter mode, then stopped
    wr(OCNT, 32'h0);
    wr(OCTRL, 32'h06);
    pins.pulse(1'b0, 5);
    rc(OCNT, 32'h5, "pin count");
    wr(OCTRL, 32'h02);
    pins.pulse(1'b0, 2);
    rc(OCNT, 32'h5, "stopped count");
    // capture on trigger edge
    wr(OCTRL, 32'h0B);
    wr(OCFG, 32'h2);
    pins.pulse(1'b1, 1);
    rc(ORLD, 32'h5, "captured count");
    rc(OCTRL, 32'h4B, "event flag on capture");
    rc(OSTAT, 32'h2, "event status");
    chk("timer irq", {31'h0, timerIrq}, 32'h1);
    chk("irq event", {31'h0, irq}, 32'h1);
    wr(OCFG, 32'h3);
    repeat (2) @(posedge clock);
    chk("timer irq up/down", {31'h0, timerIrq}, 32'h0);
    wr(OCFG, 32'h0);
    wr(OSTAT, 32'h2);
    // trigger disabled
    wr(OCTRL, 32'h03);
    wr(ORLD, 32'h0);
    pins.pulse(1'b1, 1);
    rc(ORLD, 32'h0, "no capture when disabled");
    rc(OCTRL, 32'h03, "no flag when disabled");
    // reload on trigger edge
    wr(OCTRL, 32'h0A);
    wr(ORLD, 32'hAA);
    pins.pulse(1'b1, 1);
    rc(OCNT, 32'hAA, "reload on trigger");
    rc(OCTRL, 32'h4A, "event flag on reload");
    // baud use: trigger ignored, overflow reloads, no overflow flag
    @(posedge clock);
    serialMode13 <= 1'b1;
    wr(OCNT, 32'hFFFE);
    wr(ORLD, 32'h100);
    wr(OCTRL, 32'h3F);
    tx0 = txTicks;
    rx0 = rxTicks;
    pins.pulse(1'b1, 1);
    pins.pulse(1'b0, 2);
    rc(OCNT, 32'h100, "forced reload");
    rc(OCTRL, 32'h3F, "no flags in baud use");
    chk("tx ticks", txTicks - tx0, 32'h1);
    chk("rx ticks own", rxTicks - rx0, 32'h1);
    // receive back on timer 1, transmit stays on own overflow
    wr(OCTRL, 32'h1F);
    rx0 = rxTicks;
    @(posedge clock);
    timer1Overflow <= 1'b1;
    @(posedge clock);
    timer1Overflow <= 1'b0;
    repeat (3) @(posedge clock);
    chk("rx ticks", rxTicks - rx0, 32'h1);
    chk("tx ticks kept", txTicks - tx0, 32'h1);
    wrap_up();
  end
endmodule
